// ===== include/dmb_pkg.sv
// Package for the data memory bank addressing block: map offsets, widths,
// request carrier and state types.
// Assumes one 8-bit core issuing at most one data request per clock.
package dmb_pkg;

  // ----------------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------------
  localparam int          ADDR_W      = 12;      // Full data address width
  localparam int          DATA_W      = 8;       // Data path width
  localparam int          BANK_W      = 4;       // Bank number width
  localparam int          PC_W        = 21;      // Program counter width
  localparam int          PCU_W       = 5;       // Upper holding latch width
  localparam logic [7:0]  ACC_SPLIT   = 8'h80;   // Access bank low/high split
  localparam logic [3:0]  SPEC_BANK   = 4'hF;    // Bank holding the special region
  localparam logic [11:0] SPEC_BASE   = 12'hF80; // First special register address
  localparam logic [11:0] SPEC_TOP    = 12'hFFF; // Last data address

  // ----------------------------------------------------------------------
  // Core register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_PTR2_LO  = 12'hFD9;
  localparam logic [11:0] OFS_PTR2_HI  = 12'hFDA;
  localparam logic [11:0] OFS_IND2     = 12'hFDF;
  localparam logic [11:0] OFS_BANK     = 12'hFE0;
  localparam logic [11:0] OFS_PTR1_LO  = 12'hFE1;
  localparam logic [11:0] OFS_PTR1_HI  = 12'hFE2;
  localparam logic [11:0] OFS_IND1     = 12'hFE7;
  localparam logic [11:0] OFS_ACC      = 12'hFE8;
  localparam logic [11:0] OFS_PTR0_LO  = 12'hFE9;
  localparam logic [11:0] OFS_PTR0_HI  = 12'hFEA;
  localparam logic [11:0] OFS_IND0     = 12'hFEF;
  localparam logic [11:0] OFS_PLATCH   = 12'hFF5;
  localparam logic [11:0] OFS_PPTR_LO  = 12'hFF6;
  localparam logic [11:0] OFS_PPTR_HI  = 12'hFF7;
  localparam logic [11:0] OFS_PPTR_UP  = 12'hFF8;
  localparam logic [11:0] OFS_PC_LO    = 12'hFF9;
  localparam logic [11:0] OFS_PC_HOLDH = 12'hFFA;
  localparam logic [11:0] OFS_PC_HOLDU = 12'hFFB;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;   // Core registers after reset
  localparam logic [20:0] RST_PC      = 21'h000000;
  localparam logic [20:0] PC_STEP     = 21'h000002; // Sequential fetch step

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DMB_OP_IDLE,
    DMB_OP_READ,
    DMB_OP_WRITE,
    DMB_OP_MOVE
  } dmb_op_t;

  typedef enum logic [1:0] {
    DMB_MODE_BANKED,
    DMB_MODE_ACCESS,
    DMB_MODE_ABS
  } dmb_mode_t;

  typedef enum logic {
    DMB_ST_IDLE,
    DMB_ST_MOVE
  } dmb_state_t;

  // Data request from the core execute stage
  typedef struct packed {
    dmb_op_t    op;        // Operation
    dmb_mode_t  mode;      // Address source
    logic [7:0] file_addr; // Instruction file address
    logic [11:0] abs_addr; // Full address (absolute, move words)
    logic [7:0] wdata;     // Write data
  } dmb_req_t;

endpackage

// ===== logic/dmb_top.sv
// Data memory bank addressing: address decode, core registers, storage,
// program counter low byte handling and program table pointer/latch.
// Assumes the core presents one request per clock and puts the destination
// address on abs_addr in the second cycle of a two-cycle file-to-file move.
//
// Behaviour
// - Every data byte has a 12-bit address.
// - Sixteen banks of 256 bytes, direct reaches one.
// - Bank number from low four select bits.
// - Upper four bank select bits hold nothing.
// - Unimplemented locations read back as zero.
// - Special registers fill 0xF80 to 0xFFF.
// - Special registers allocated downward from the top.
// - Storage starts at bank 0, grows upward.
// - Storage is never initialised by any reset.
// - Pointers hold full address, ignore bank select.
// - Access bank reachable regardless of bank select.
// - File-to-file move takes two cycles, copies anywhere.
// - Accumulator added to low byte advances counter.
// - Computed jump lands on a literal return.
// - Table pointer addresses bytes, latch holds byte.
// - Each table transfer moves exactly one byte.
// - Indirect ports redirect through their pointer.
// - Low byte write loads upper counter from latches.
// - Low byte read copies counter upper into latches.
// - Counter bit zero is always zero.
`timescale 1ns/10ps

module dmb_top #(
  parameter int STORE_DEPTH = 256   // Implemented storage bytes from address 0
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire dmb_pkg::dmb_req_t req,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   move_busy,
  input  wire logic              pc_inc,
  input  wire logic              pc_load,
  input  wire logic [20:0]       pc_target,
  output logic [20:0]            pc,
  output logic [7:0]             accumulator,
  input  wire logic              tbl_rd,
  input  wire logic [7:0]        prog_rdata,
  input  wire logic              tbl_wr,
  output logic [20:0]            prog_addr,
  output logic [7:0]             prog_wdata,
  output logic                   prog_wr_req
);

  localparam int STORE_AW = (STORE_DEPTH > 1) ? $clog2(STORE_DEPTH) : 1;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dmb_pkg::dmb_state_t state_ff, nxt_state;       // Move sequencer
  logic [7:0]          move_data_ff, nxt_move_data; // Byte in flight
  logic [3:0]          bank_ff, nxt_bank;         // Bank select
  logic [7:0]          ptr_lo_ff [3];             // Pointer low bytes
  logic [7:0]          nxt_ptr_lo [3];
  logic [3:0]          ptr_hi_ff [3];             // Pointer high nibbles
  logic [3:0]          nxt_ptr_hi [3];
  logic [7:0]          acc_ff, nxt_acc;           // Working accumulator
  logic [20:0]         pc_ff, nxt_pc;             // Program counter
  logic [7:0]          holdh_ff, nxt_holdh;       // High holding latch
  logic [4:0]          holdu_ff, nxt_holdu;       // Upper holding latch
  logic [20:0]         pptr_ff, nxt_pptr;         // Program table pointer
  logic [7:0]          platch_ff, nxt_platch;     // Program table latch
  logic                pwr_ff, nxt_pwr;           // Table write request
  logic [7:0]          rdat_ff, nxt_rdat;         // Read data
  logic                rval_ff, nxt_rval;         // Read valid
  logic [7:0]          store_mem [STORE_DEPTH];   // Storage, never reset

  // ----------------------------------------------------------------------
  // Decode signals
  // ----------------------------------------------------------------------
  logic        use_abs;    // Full address from request
  logic [11:0] base_addr;  // Address before redirection
  logic [11:0] eff_addr;   // Address after redirection
  logic        rd_en;      // Read taken this cycle
  logic        wr_en;      // Write taken this cycle
  logic [7:0]  wr_byte;    // Byte to write
  logic [7:0]  rd_val;     // Read mux result
  logic        rd_impl;    // Location exists
  logic        store_hit;  // Location is storage
  logic [STORE_AW-1:0] store_idx; // Storage index

  // ----------------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------------
  // Forms the base address, then redirects indirect ports
  always_comb begin
    use_abs = (state_ff == dmb_pkg::DMB_ST_MOVE) || (req.op == dmb_pkg::DMB_OP_MOVE);
    if (use_abs) begin
      base_addr = req.abs_addr;
    end else begin
      unique case (req.mode)
        dmb_pkg::DMB_MODE_BANKED: base_addr = {bank_ff, req.file_addr};
        dmb_pkg::DMB_MODE_ACCESS: begin
          if (req.file_addr < dmb_pkg::ACC_SPLIT) begin
            base_addr = {4'h0, req.file_addr};
          end else begin
            base_addr = {dmb_pkg::SPEC_BANK, req.file_addr};
          end
        end
        default: base_addr = req.abs_addr;
      endcase
    end
    case (base_addr)
      dmb_pkg::OFS_IND0: eff_addr = {ptr_hi_ff[0], ptr_lo_ff[0]};
      dmb_pkg::OFS_IND1: eff_addr = {ptr_hi_ff[1], ptr_lo_ff[1]};
      dmb_pkg::OFS_IND2: eff_addr = {ptr_hi_ff[2], ptr_lo_ff[2]};
      default:           eff_addr = base_addr;
    endcase
    rd_en   = (state_ff == dmb_pkg::DMB_ST_IDLE) &&
              ((req.op == dmb_pkg::DMB_OP_READ) || (req.op == dmb_pkg::DMB_OP_MOVE));
    wr_en   = (state_ff == dmb_pkg::DMB_ST_MOVE) ||
              (req.op == dmb_pkg::DMB_OP_WRITE);
    wr_byte = (state_ff == dmb_pkg::DMB_ST_MOVE) ? move_data_ff : req.wdata;
    store_hit = (32'(eff_addr) < STORE_DEPTH) && (eff_addr < dmb_pkg::SPEC_BASE);
    store_idx = eff_addr[STORE_AW-1:0];
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // special registers at the top of bank 15
  always_comb begin
    rd_impl = 1'b1;
    case (eff_addr)
      dmb_pkg::OFS_PTR0_LO:  rd_val = ptr_lo_ff[0];
      dmb_pkg::OFS_PTR1_LO:  rd_val = ptr_lo_ff[1];
      dmb_pkg::OFS_PTR2_LO:  rd_val = ptr_lo_ff[2];
      dmb_pkg::OFS_PTR0_HI:  rd_val = {4'h0, ptr_hi_ff[0]};
      dmb_pkg::OFS_PTR1_HI:  rd_val = {4'h0, ptr_hi_ff[1]};
      dmb_pkg::OFS_PTR2_HI:  rd_val = {4'h0, ptr_hi_ff[2]};
      dmb_pkg::OFS_BANK:     rd_val = {4'h0, bank_ff};
      dmb_pkg::OFS_ACC:      rd_val = acc_ff;
      dmb_pkg::OFS_PLATCH:   rd_val = platch_ff;
      dmb_pkg::OFS_PPTR_LO:  rd_val = pptr_ff[7:0];
      dmb_pkg::OFS_PPTR_HI:  rd_val = pptr_ff[15:8];
      dmb_pkg::OFS_PPTR_UP:  rd_val = {3'h0, pptr_ff[20:16]};
      dmb_pkg::OFS_PC_LO:    rd_val = pc_ff[7:0];
      dmb_pkg::OFS_PC_HOLDH: rd_val = holdh_ff;
      dmb_pkg::OFS_PC_HOLDU: rd_val = {3'h0, holdu_ff};
      default: begin
        rd_impl = store_hit;
        rd_val  = store_hit ? store_mem[store_idx] : 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Core register next state
  // ----------------------------------------------------------------------
  // Register writes, move sequencing, counter and table handling
  always_comb begin
    nxt_state     = state_ff;
    nxt_move_data = move_data_ff;
    nxt_bank      = bank_ff;
    nxt_ptr_lo    = ptr_lo_ff;
    nxt_ptr_hi    = ptr_hi_ff;
    nxt_acc       = acc_ff;
    nxt_pc        = pc_ff;
    nxt_holdh     = holdh_ff;
    nxt_holdu     = holdu_ff;
    nxt_pptr      = pptr_ff;
    nxt_platch    = platch_ff;
    nxt_pwr       = tbl_wr;
    nxt_rval      = rd_en && (req.op == dmb_pkg::DMB_OP_READ);
    nxt_rdat      = rd_en ? rd_val : rdat_ff;
    // Counter stepping and absolute branches bypass the latches
    if (pc_load) begin
      nxt_pc = {pc_target[20:1], 1'b0};
    end else if (pc_inc) begin
      nxt_pc = pc_ff + dmb_pkg::PC_STEP;
    end
    unique case (state_ff)
      dmb_pkg::DMB_ST_IDLE: begin
        if (req.op == dmb_pkg::DMB_OP_MOVE) begin
          nxt_move_data = rd_val;
          nxt_state     = dmb_pkg::DMB_ST_MOVE;
        end
      end
      dmb_pkg::DMB_ST_MOVE: nxt_state = dmb_pkg::DMB_ST_IDLE;
    endcase
    // low byte read snapshots upper counter
    if (rd_en && (eff_addr == dmb_pkg::OFS_PC_LO)) begin
      nxt_holdh = pc_ff[15:8];
      nxt_holdu = pc_ff[20:16];
    end
    if (tbl_rd) begin
      nxt_platch = prog_rdata;
    end
    if (wr_en) begin
      case (eff_addr)
        dmb_pkg::OFS_PTR0_LO:  nxt_ptr_lo[0] = wr_byte;
        dmb_pkg::OFS_PTR1_LO:  nxt_ptr_lo[1] = wr_byte;
        dmb_pkg::OFS_PTR2_LO:  nxt_ptr_lo[2] = wr_byte;
        dmb_pkg::OFS_PTR0_HI:  nxt_ptr_hi[0] = wr_byte[3:0];
        dmb_pkg::OFS_PTR1_HI:  nxt_ptr_hi[1] = wr_byte[3:0];
        dmb_pkg::OFS_PTR2_HI:  nxt_ptr_hi[2] = wr_byte[3:0];
        dmb_pkg::OFS_BANK:     nxt_bank = wr_byte[3:0];
        dmb_pkg::OFS_ACC:      nxt_acc = wr_byte;
        dmb_pkg::OFS_PLATCH:   nxt_platch = wr_byte;
        dmb_pkg::OFS_PPTR_LO:  nxt_pptr[7:0] = wr_byte;
        dmb_pkg::OFS_PPTR_HI:  nxt_pptr[15:8] = wr_byte;
        dmb_pkg::OFS_PPTR_UP:  nxt_pptr[20:16] = wr_byte[4:0];
        dmb_pkg::OFS_PC_HOLDH: nxt_holdh = wr_byte;
        dmb_pkg::OFS_PC_HOLDU: nxt_holdu = wr_byte[4:0];
        dmb_pkg::OFS_PC_LO:    nxt_pc = {holdu_ff, holdh_ff, wr_byte[7:1], 1'b0};
        default:               nxt_pc = nxt_pc;
      endcase
    end
  end

  // Core register flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff     <= dmb_pkg::DMB_ST_IDLE;
      move_data_ff <= dmb_pkg::RST_BYTE;
      bank_ff      <= 4'h0;
      ptr_lo_ff    <= '{default: dmb_pkg::RST_BYTE};
      ptr_hi_ff    <= '{default: 4'h0};
      acc_ff       <= dmb_pkg::RST_BYTE;
      pc_ff        <= dmb_pkg::RST_PC;
      holdh_ff     <= dmb_pkg::RST_BYTE;
      holdu_ff     <= 5'h00;
      pptr_ff      <= 21'h000000;
      platch_ff    <= dmb_pkg::RST_BYTE;
      pwr_ff       <= 1'b0;
      rdat_ff      <= dmb_pkg::RST_BYTE;
      rval_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      move_data_ff <= nxt_move_data;
      bank_ff      <= nxt_bank;
      ptr_lo_ff    <= nxt_ptr_lo;
      ptr_hi_ff    <= nxt_ptr_hi;
      acc_ff       <= nxt_acc;
      pc_ff        <= nxt_pc;
      holdh_ff     <= nxt_holdh;
      holdu_ff     <= nxt_holdu;
      pptr_ff      <= nxt_pptr;
      platch_ff    <= nxt_platch;
      pwr_ff       <= nxt_pwr;
      rdat_ff      <= nxt_rdat;
      rval_ff      <= nxt_rval;
    end
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // storage has no reset term
  always_ff @(posedge mclk) begin
    if (wr_en && store_hit) begin
      store_mem[store_idx] <= wr_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rd_data     = rdat_ff;
  assign rd_valid    = rval_ff;
  assign move_busy   = (state_ff == dmb_pkg::DMB_ST_MOVE);
  assign pc          = pc_ff;
  assign accumulator = acc_ff;
  assign prog_addr   = pptr_ff;
  assign prog_wdata  = platch_ff;
  assign prog_wr_req = pwr_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_move_take;
    state_ff == dmb_pkg::DMB_ST_IDLE && req.op == dmb_pkg::DMB_OP_MOVE;
  endsequence
  sequence s_move_end;
    move_busy ##1 !move_busy;
  endsequence

  property p_move_two;
    s_move_take |=> s_move_end;
  endproperty
  a_move_two: assert property (p_move_two) else $error("move not two cycles");

  property p_unimpl_zero;
    rd_en && !rd_impl && req.op == dmb_pkg::DMB_OP_READ |=> rd_valid && rd_data == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented not zero");

  property p_bank_upper;
    rd_en && eff_addr == dmb_pkg::OFS_BANK && req.op == dmb_pkg::DMB_OP_READ
      |=> rd_data[7:4] == 4'h0;
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper bits set");

  property p_banked_addr;
    !use_abs && req.mode == dmb_pkg::DMB_MODE_BANKED |-> base_addr == {bank_ff, req.file_addr};
  endproperty
  a_banked_addr: assert property (p_banked_addr) else $error("banked address wrong");

  property p_access_high;
    !use_abs && req.mode == dmb_pkg::DMB_MODE_ACCESS && req.file_addr[7]
      |-> base_addr[11:8] == 4'hF;
  endproperty
  a_access_high: assert property (p_access_high) else $error("access bank wrong");

  property p_ind_redirect;
    base_addr == dmb_pkg::OFS_IND1 |-> eff_addr == {ptr_hi_ff[1], ptr_lo_ff[1]};
  endproperty
  a_ind_redirect: assert property (p_ind_redirect) else $error("redirect wrong");

  property p_pcl_write;
    wr_en && eff_addr == dmb_pkg::OFS_PC_LO
      |=> pc_ff[20:8] == {$past(holdu_ff), $past(holdh_ff)};
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("latches not loaded");

  property p_pcl_read;
    rd_en && eff_addr == dmb_pkg::OFS_PC_LO |=> holdh_ff == $past(pc_ff[15:8]);
  endproperty
  a_pcl_read: assert property (p_pcl_read) else $error("latch not captured");

  property p_pc_even;
    pc_ff[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("counter odd");

  property p_tbl_byte;
    tbl_rd && !wr_en |=> platch_ff == $past(prog_rdata);
  endproperty
  a_tbl_byte: assert property (p_tbl_byte) else $error("table latch wrong");

  // Write request follows the strobe by exactly one cycle
  property p_wr_req;
    prog_wr_req == $past(tbl_wr);
  endproperty
  a_wr_req: assert property (p_wr_req) else $error("table write request wrong");

  // Sequential step keeps the counter word aligned
  property p_pc_step;
    pc_inc && !pc_load && !(wr_en && eff_addr == dmb_pkg::OFS_PC_LO)
      |=> pc_ff == $past(pc_ff) + dmb_pkg::PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter step wrong");

  // Bank select keeps only the low nibble of a write
  property p_bank_write;
    wr_en && eff_addr == dmb_pkg::OFS_BANK |=> bank_ff == $past(wr_byte[3:0]);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank select not loaded");

endmodule

// ===== verif/dmb_prog_mem_model.sv
// Program memory model facing the table pointer and latch of the block.
// Assumes byte addressing and one write request pulse per stored byte.
`timescale 1ns/10ps

module dmb_prog_mem_model (
  input  wire logic        mclk,
  input  wire logic [20:0] prog_addr,
  input  wire logic [7:0]  prog_wdata,
  input  wire logic        prog_wr_req,
  output logic [7:0]       prog_rdata,
  output logic [20:0]      last_wr_addr,
  output logic [7:0]       last_wr_data
);
  // ----------------------------------------------------------------
  // Byte read and byte write
  // ----------------------------------------------------------------
  // byte addressed read
  // Read byte is a fixed pattern of its byte address
  assign prog_rdata = prog_addr[7:0] ^ prog_addr[15:8] ^ 8'hC3;
  // one byte each
  // Capture each written byte with its address
  always @(posedge mclk) begin
    if (prog_wr_req) begin
      last_wr_addr <= prog_addr;
      last_wr_data <= prog_wdata;
    end
  end
endmodule

// ===== verif/tb_data_memory_bank_addressing.sv
// Self-checking bench for the data memory bank addressing block.
// Assumes the core side contract: one request per edge, read answered next cycle.
`timescale 1ns/10ps

module tb_data_memory_bank_addressing;
  // ----------------------------------------------------------------
  // Signals and shorthands
  // ----------------------------------------------------------------
  localparam dmb_pkg::dmb_mode_t BNK = dmb_pkg::DMB_MODE_BANKED;
  localparam dmb_pkg::dmb_mode_t ACC = dmb_pkg::DMB_MODE_ACCESS;
  localparam dmb_pkg::dmb_mode_t ABS = dmb_pkg::DMB_MODE_ABS;
  logic              mclk, rstn, pc_inc, pc_load, tbl_rd, tbl_wr;
  dmb_pkg::dmb_req_t req;
  logic [20:0]       pc_target, pc, prog_addr, last_wr_addr;
  logic [7:0]        rd_data, accumulator, prog_rdata, prog_wdata, last_wr_data;
  logic              rd_valid, move_busy, prog_wr_req;
  int                n_fail, n_compared;

  // Storage covers banks 0 to 2 only
  dmb_top #(.STORE_DEPTH(768)) dmb_top_i (.mclk(mclk), .rstn(rstn), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .move_busy(move_busy), .pc_inc(pc_inc),
    .pc_load(pc_load), .pc_target(pc_target), .pc(pc), .accumulator(accumulator),
    .tbl_rd(tbl_rd), .prog_rdata(prog_rdata), .tbl_wr(tbl_wr), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_wr_req(prog_wr_req));
  dmb_prog_mem_model dmb_prog_mem_model_i (.mclk(mclk), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_wr_req(prog_wr_req), .prog_rdata(prog_rdata),
    .last_wr_addr(last_wr_addr), .last_wr_data(last_wr_data));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // One request held for one edge, then idle
  task automatic put(dmb_pkg::dmb_op_t op, dmb_pkg::dmb_mode_t md, logic [11:0] a,
                     logic [7:0] d);
    @(posedge mclk);
    req <= '{op, md, a[7:0], a, d};
    @(posedge mclk);
    req.op <= dmb_pkg::DMB_OP_IDLE;
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    put(dmb_pkg::DMB_OP_WRITE, ABS, a, d);
  endtask
  // Read and judge the answer in the following cycle
  task automatic rd(dmb_pkg::dmb_mode_t md, logic [11:0] a, logic [7:0] exp);
    put(dmb_pkg::DMB_OP_READ, md, a, 8'h00);
    @(negedge mclk);
    check(rd_valid, 32'h1);
    check(rd_data, exp);
  endtask
  // One-cycle pulse on {pc_load, pc_inc, tbl_rd, tbl_wr}
  task automatic strobe(logic [3:0] m);
    @(posedge mclk);
    {pc_load, pc_inc, tbl_rd, tbl_wr} <= m;
    @(posedge mclk);
    {pc_load, pc_inc, tbl_rd, tbl_wr} <= 4'h0;
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Counts: compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Core registers come out of reset at zero; storage survives a reset
  task automatic t_reset();
    logic [11:0] ofs[9] = '{12'hFE0, 12'hFE8, 12'hFE9, 12'hFEA, 12'hFF5,
                            12'hFF6, 12'hFF9, 12'hFFA, 12'hFFB};
    check(pc, dmb_pkg::RST_PC);
    foreach (ofs[i]) rd(ABS, ofs[i], dmb_pkg::RST_BYTE);
    wr(12'h000, 8'h77);
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    rd(ABS, 12'h000, 8'h77);
    $display("test reset done");
  endtask
  // Banked, access bank and unimplemented places
  task automatic t_bank();
    wr(12'h215, 8'hA5);
    wr(12'h015, 8'h3C);
    wr(12'hFE0, 8'hF2);
    rd(ABS, 12'hFE0, 8'h02);
    rd(BNK, 12'h015, 8'hA5);
    rd(ACC, 12'h015, 8'h3C);
    wr(12'hFE8, 8'h06);
    rd(ACC, 12'h0E8, 8'h06);
    check(accumulator, 32'h06);
    wr(12'hF81, 8'hFF);
    rd(ABS, 12'hF81, 8'h00);
    rd(ABS, 12'h400, 8'h00);
    $display("test bank done");
  endtask
  // Pointers redirect the indirect ports, bank select unused
  task automatic t_indirect();
    wr(12'hFE0, 8'h00);
    wr(12'hFEA, 8'hF2);
    wr(12'hFE9, 8'h15);
    rd(ABS, 12'hFEA, 8'h02);
    rd(ABS, 12'hFEF, 8'hA5);
    wr(12'hFE2, 8'h01);
    wr(12'hFE1, 8'h00);
    wr(12'hFE7, 8'h99);
    rd(ABS, 12'h100, 8'h99);
    wr(12'hFDA, 8'h0F);
    wr(12'hFD9, 8'hEF);
    rd(ABS, 12'hFDF, 8'h00);
    $display("test indirect done");
  endtask
  // Two-cycle file-to-file move within bank 2
  task automatic t_move();
    @(posedge mclk);
    req <= '{dmb_pkg::DMB_OP_MOVE, ABS, 8'h00, 12'h215, 8'h00};
    @(posedge mclk);
    req <= '{dmb_pkg::DMB_OP_IDLE, ABS, 8'h00, 12'h2FF, 8'h00};
    @(negedge mclk);
    check(move_busy, 32'h1);
    @(negedge mclk);
    check(move_busy, 32'h0);
    rd(ABS, 12'h2FF, 8'hA5);
    $display("test move done");
  endtask
  // Counter low byte, holding latches and computed jump
  task automatic t_pc();
    wr(12'hFFA, 8'h12);
    wr(12'hFFB, 8'hFF);
    rd(ABS, 12'hFFB, 8'h1F);
    wr(12'hFF9, 8'h35);
    @(negedge mclk);
    check(pc, 32'h1F1234);
    strobe(4'h4);
    @(negedge mclk);
    check(pc, 32'h1F1236);
    wr(12'hFFA, 8'h00);
    wr(12'hFFB, 8'h00);
    rd(ABS, 12'hFF9, 8'h36);
    rd(ABS, 12'hFFA, 8'h12);
    rd(ABS, 12'hFFB, 8'h1F);
    // Jump ahead by the accumulator value
    wr(12'hFF9, 8'h36 + accumulator);
    @(negedge mclk);
    check(pc, 32'h1F123C);
    // Literal return at the target loads the accumulator
    wr(12'hFE8, 8'h4B);
    @(negedge mclk);
    check(accumulator, 32'h4B);
    @(posedge mclk);
    pc_target <= 21'h0ABCD5;
    strobe(4'h8);
    @(negedge mclk);
    check(pc, 32'h0ABCD4);
    $display("test pc done");
  endtask
  // Table pointer and latch move one byte per transfer
  task automatic t_table();
    wr(12'hFF6, 8'h34);
    wr(12'hFF7, 8'h12);
    wr(12'hFF8, 8'h01);
    @(negedge mclk);
    check(prog_addr, 32'h011234);
    strobe(4'h2);
    rd(ABS, 12'hFF5, 8'h34 ^ 8'h12 ^ 8'hC3);
    wr(12'hFF5, 8'h5A);
    strobe(4'h1);
    @(negedge mclk);
    check(prog_wr_req, 32'h1);
    @(negedge mclk);
    check(prog_wr_req, 32'h0);
    check(last_wr_data, 32'h5A);
    check(last_wr_addr, 32'h011234);
    $display("test table done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {rstn, pc_inc, pc_load, tbl_rd, tbl_wr} = 5'h00;
    req = '0;
    pc_target = 21'h000000;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_bank();
    t_indirect();
    t_move();
    t_pc();
    t_table();
    finish_test();
  end
  // Whole run needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
endmodule
